// *** dv/ufm_config_bench.sv ***
// self-checking bench for the serial configuration register block
`default_nettype none
`include "ufm_map.svh"
module ufm_config_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, txBitIn = 1'b1, rxParityIn = 1'b0;
   logic rxCharStrobe = 1'b0, rxIsFlowChar = 1'b0, swFlowActive = 1'b0, extIrqIn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, txWord = 8'h00, rxWord = 8'h01;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic [3:0] wstrb = 4'h1, wordBits, modemStatus;
   logic [5:0] txCount = 6'h00, rxCount = 6'h00;
   logic [1:0] bresp, rresp, resp;
   logic [2:0] stopHalves;
   logic awready, wready, bvalid, arready, rvalid, rxToCore, parityEnable, txParityBit;
   logic rxParityErr, divisorSelect, autoRtsReady, xonAnyEnable, resumeTx, storeChar;
   logic wakeIrqEnable, baudTick, txIrq, rxIrq, rxPinIn, irRxIn, ctsN, dsrN, cdN;
   logic ring_indicator_n, serialTxOut, irTxOut, dtrN, rtsN, intOut, intOe, breakSeen;
   logic [7:0] parCfg [5] = '{8'h03, 8'h0b, 8'h2b, 8'h3b, 8'h1b};
   logic [4:0] parExp = 5'b10100;
   int rxLvl [4] = '{8, 16, 24, 28};
   int txLvl [4] = '{16, 8, 24, 30};
   int badCount = 0, checkCount = 0, n;
   ufm_config ufm_config_inst (.*);
   ufm_remote_line ufm_remote_line_inst (.*);
   // ----------------------------------------
   // bus, strobe, tick counting, compare and closing tasks
   // ----------------------------------------
   task automatic chkw(input logic [31:0] g, input logic [31:0] e);
      checkCount++;
      if (g !== e) begin
         badCount++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chkb(input logic g, input logic e);
      chkw({31'h0, g}, {31'h0, e});
   endtask
   // ends two edges late so config outputs have followed the register
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      resp = bresp;
      bready <= 1'b0;
      repeat (2) @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      rv = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   task automatic pulse();
      @(posedge clock);
      rxCharStrobe <= 1'b1;
      @(posedge clock);
      rxCharStrobe <= 1'b0;
      #1;
   endtask
   task automatic ticks();
      n = 0;
      repeat (8) begin
         @(posedge clock);
         n += int'(baudTick);
      end
   endtask
   task automatic summarize();
      if (badCount == 0 && checkCount > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // clock, watchdog and tests
   // ----------------------------------------
   initial begin
      forever #10 clock = ~clock;
   end
   initial begin
      #400000;
      badCount++;
      summarize();
   end
   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      chkb(dtrN, 1'b1);
      chkb(rtsN, 1'b1);
      chkw(32'(wordBits), 32'h5);
      chkb(divisorSelect, 1'b0);
      rd(`UFM_OFS_LINE_FORMAT);
      chkw(rv, 32'h0);
      chkw(32'(modemStatus), 32'h9);
      for (int i = 0; i < 4; i++) begin
         wr(`UFM_OFS_LINE_FORMAT, 8'(i) | 8'h04);
         chkw(32'(wordBits), 32'(5 + i));
         chkw(32'(stopHalves), (i == 0) ? 32'h3 : 32'h4);
      end
      txWord <= 8'h01;
      for (int i = 0; i < 5; i++) begin
         wr(`UFM_OFS_LINE_FORMAT, parCfg[i]);
         chkb(parityEnable, parCfg[i][3]);
         if (i > 0) chkb(txParityBit, parExp[i]);
      end
      pulse();
      chkb(rxParityErr, 1'b1);
      rxParityIn <= 1'b1;
      pulse();
      chkb(rxParityErr, 1'b0);
      wr(`UFM_OFS_LINE_FORMAT, 8'hc3);
      chkb(serialTxOut, 1'b0);
      chkb(divisorSelect, 1'b1);
      repeat (12) @(posedge clock);
      chkb(breakSeen, 1'b1);
      wr(`UFM_OFS_LINE_FORMAT, 8'h03);
      chkb(serialTxOut, 1'b1);
      chkb(divisorSelect, 1'b0);
      wr(`UFM_OFS_MODEM_OUT, 8'h0b);
      chkb(dtrN, 1'b0);
      chkb(rtsN, 1'b0);
      chkb(autoRtsReady, 1'b1);
      chkb(intOe, 1'b1);
      wr(`UFM_OFS_MODEM_OUT, 8'h1d);
      chkw(32'(modemStatus), 32'he);
      txBitIn <= 1'b0;
      repeat (2) @(posedge clock);
      chkb(rxToCore, 1'b0);
      chkb(serialTxOut, 1'b1);
      txBitIn <= 1'b1;
      rd(`UFM_OFS_MODEM_OUT);
      chkw(rv, 32'h1d);
      for (int i = 0; i < 4; i++) begin
         wr(`UFM_OFS_FIFO_SETUP, 8'(i << 6) | 8'h09);
         rd(`UFM_OFS_STATUS);
         chkw(32'(rv[5:0]), rxLvl[i]);
      end
      chkb(wakeIrqEnable, 1'b0);
      wr(`UFM_OFS_FIFO_SETUP, 8'h40);
      rd(`UFM_OFS_STATUS);
      chkw(rv & 32'h13f, 32'h01c);
      rxCount <= 6'd27;
      repeat (2) @(posedge clock);
      chkb(rxIrq, 1'b0);
      rxCount <= 6'd28;
      repeat (2) @(posedge clock);
      chkb(rxIrq, 1'b1);
      wr(`UFM_OFS_ENHANCED, 8'h10);
      for (int i = 0; i < 4; i++) begin
         wr(`UFM_OFS_FIFO_SETUP, 8'(i << 4) | 8'h09);
         rd(`UFM_OFS_STATUS);
         chkw(32'(rv[5:0]), txLvl[i]);
      end
      chkb(wakeIrqEnable, 1'b1);
      chkb(rxIrq, 1'b0);
      chkb(txIrq, 1'b1);
      txCount <= 6'd31;
      repeat (3) @(posedge clock);
      chkb(txIrq, 1'b0);
      chkb(intOut, 1'b0);
      txCount <= 6'd29;
      repeat (3) @(posedge clock);
      chkb(txIrq, 1'b1);
      chkb(intOut, 1'b1);
      wr(`UFM_OFS_MODEM_OUT, 8'h00);
      ticks();
      chkw(n, 8);
      wr(`UFM_OFS_MODEM_OUT, 8'h80);
      ticks();
      chkw(n, 2);
      wr(`UFM_OFS_MODEM_OUT, 8'h20);
      chkb(xonAnyEnable, 1'b1);
      rxIsFlowChar <= 1'b1;
      swFlowActive <= 1'b1;
      pulse();
      chkb(resumeTx, 1'b1);
      chkb(storeChar, 1'b0);
      rxIsFlowChar <= 1'b0;
      pulse();
      chkb(storeChar, 1'b1);
      wr(`UFM_OFS_MODEM_OUT, 8'h40);
      chkb(irTxOut, 1'b0);
      txBitIn <= 1'b0;
      repeat (2) @(posedge clock);
      chkb(irTxOut, 1'b1);
      chkb(serialTxOut, 1'b1);
      txBitIn <= 1'b1;
      // unmapped place answers with an error, write-only place reads zero
      wr(8'h20, 8'hff);
      chkw(32'(resp), 32'h2);
      rd(8'h20);
      chkw(32'(resp), 32'h2);
      rd(`UFM_OFS_FIFO_SETUP);
      chkw(rv, 32'h0);
      summarize();
   end
endmodule
`default_nettype wire

// *** dv/ufm_remote_line.sv ***
// remote transceiver and modem model on the far side of the line
`default_nettype none
module ufm_remote_line #(
   parameter int BREAK_LEN = 10
) (
   // clock
   input wire logic clock,
   // line from the block
   input wire logic serialTxOut,
   input wire logic irTxOut,
   // line and modem pins towards the block
   output logic rxPinIn,
   output logic irRxIn,
   output logic ctsN,
   output logic dsrN,
   output logic ring_indicator_n,
   output logic cdN,
   // break detector
   output logic breakSeen
);
   timeunit 1ns;
   timeprecision 1ns;
   int lowRun = 0;
   // ----------------------------------------
   // idle line, fixed modem levels and break detection
   // ----------------------------------------
   // mark on the wire; infrared receiver stays dark between frames
   assign rxPinIn = 1'b1;
   assign irRxIn = 1'b0;
   // clear to send and carrier up, no ring, data set not ready
   assign ctsN = 1'b0;
   assign dsrN = 1'b1;
   assign ring_indicator_n = 1'b1;
   assign cdN = 1'b0;
   // a low longer than a frame counts as break, not as data
   always @(posedge clock) lowRun <= serialTxOut ? 0 : lowRun + 1;
   assign breakSeen = (lowRun >= BREAK_LEN);
endmodule
`default_nettype wire

// *** verilog/ufm_config.sv ***
// serial line, fifo trigger and modem control register block
// Operation
// - wake-up interrupt enable works only with enhanced functions on
// - transmit event below level, or on empty if level never exceeded
// - transmit trigger codes give 16, 8, 24, 30; enhanced mode only
// - receive event when receive count crosses the trigger level
// - receive trigger codes give 8, 16, 24, 28
// - one shared trigger level; last selection written governs both sides
// - word length field gives 5, 6, 7 or 8 bits
// - stop bit: one, or 1.5 for 5 bits and 2 otherwise
// - parity enable adds transmit parity and receive checking
// - unforced parity is odd when bit 4 clear, even when set
// - forced parity is 1 when bit 4 clear, 0 when set
// - break holds transmit output low until software clears it
// - bit 7 selects divisor latch registers
// - terminal-ready pin is inverse of bit 0, held high in loopback
// - request-to-send pin is inverse of bit 1, held high in loopback; needed for auto flow
// - bit 2 supplies ring indicator during loopback
// - bit 3 enables interrupt output; drives second user output in loopback
// - bit 4 enables local loopback; clear after reset
// - xon-any resumes transmit on any character, enhanced mode only; flow characters not stored while software flow control is active
// - infrared mode routes serial lines through infrared path, idles low; enhanced mode only
// - bit 7 divides baud clock by four, enhanced mode only
// - fifo setup writes without enable bit leave other fields unchanged
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`default_nettype none
`include "ufm_map.svh"
module ufm_config #(
   parameter int FIFO_DEPTH = `UFM_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // axi4-lite write
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // transmitter and receiver core
   input wire logic txBitIn,
   input wire logic [7:0] txWord,
   input wire logic [7:0] rxWord,
   input wire logic rxParityIn,
   input wire logic rxCharStrobe,
   input wire logic rxIsFlowChar,
   input wire logic swFlowActive,
   input wire logic extIrqIn,
   input wire ufm_pkg::ufm_level_t txCount,
   input wire ufm_pkg::ufm_level_t rxCount,
   output logic rxToCore,
   output logic [3:0] wordBits,
   output logic [2:0] stopHalves,
   output logic parityEnable,
   output logic txParityBit,
   output logic rxParityErr,
   output logic divisorSelect,
   output logic autoRtsReady,
   output logic xonAnyEnable,
   output logic resumeTx,
   output logic storeChar,
   output logic wakeIrqEnable,
   output logic baudTick,
   output logic txIrq,
   output logic rxIrq,
   // serial and modem pins
   input wire logic rxPinIn,
   input wire logic irRxIn,
   input wire logic ctsN,
   input wire logic dsrN,
   input wire logic ring_indicator_n,
   input wire logic cdN,
   output logic serialTxOut,
   output logic irTxOut,
   output logic dtrN,
   output logic rtsN,
   output logic intOut,
   output logic intOe,
   output logic [3:0] modemStatus
);
   import ufm_pkg::*;
   generate
      if (FIFO_DEPTH != `UFM_FIFO_DEPTH) begin : g_bad
         $error("trigger table is fixed for this fifo depth");
      end
   endgenerate
   // ----------------------------------------
   // decoders
   // ----------------------------------------
   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a == `UFM_OFS_FIFO_SETUP) || (a == `UFM_OFS_LINE_FORMAT) ||
         (a == `UFM_OFS_MODEM_OUT) || (a == `UFM_OFS_ENHANCED) ||
         (a == `UFM_OFS_STATUS);
   endfunction
   function automatic ufm_level_t txTable(input logic [1:0] c);
      case (c)
         2'h0: txTable = `UFM_TX_TRIG_0;
         2'h1: txTable = `UFM_TX_TRIG_1;
         2'h2: txTable = `UFM_TX_TRIG_2;
         default: txTable = `UFM_TX_TRIG_3;
      endcase
   endfunction
   function automatic ufm_level_t rxTable(input logic [1:0] c);
      case (c)
         2'h0: rxTable = `UFM_RX_TRIG_0;
         2'h1: rxTable = `UFM_RX_TRIG_1;
         2'h2: rxTable = `UFM_RX_TRIG_2;
         default: rxTable = `UFM_RX_TRIG_3;
      endcase
   endfunction
   // parity bit for a character under the given line format
   function automatic logic parityOf(input logic [7:0] d, input logic [7:0] lf);
      logic [7:0] m;
      m = d & (8'hff >> (2'h3 - lf[1:0]));
      if (lf[`UFM_LF_PAR_FORCE]) begin
         parityOf = !lf[`UFM_LF_PAR_EVEN];
      end else begin
         parityOf = lf[`UFM_LF_PAR_EVEN] ? ^m : !(^m);
      end
   endfunction
   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   ufm_wstate_t wState_q, wState_d;
   logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
   logic [7:0] wAddr_q, wAddr_d;
   logic [31:0] wData_q, wData_d;
   logic [3:0] wStrb_q, wStrb_d;
   logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
   logic [1:0] bresp_d, rresp_d;
   logic [31:0] rdata_d;
   logic wrDo;
   logic [7:0] fifoSetup_q, lineFmt_q, modemCtl_q, enhanced_q;
   ufm_level_t trig_q;
   logic fifoEn_q;
   always_comb begin
      wState_d = wState_q;
      awHeld_d = awHeld_q;
      wHeld_d = wHeld_q;
      wAddr_d = wAddr_q;
      wData_d = wData_q;
      wStrb_d = wStrb_q;
      bvalid_d = bvalid;
      bresp_d = bresp;
      rvalid_d = rvalid;
      rresp_d = rresp;
      rdata_d = rdata;
      wrDo = 1'b0;
      if (awready && awvalid) begin
         awHeld_d = 1'b1;
         wAddr_d = awaddr;
      end
      if (wready && wvalid) begin
         wHeld_d = 1'b1;
         wData_d = wdata;
         wStrb_d = wstrb;
      end
      case (wState_q)
         UFM_W_IDLE: begin
            if (awHeld_q && wHeld_q) begin
               wrDo = 1'b1;
               awHeld_d = 1'b0;
               wHeld_d = 1'b0;
               bvalid_d = 1'b1;
               bresp_d = isMapped(wAddr_q) ? `UFM_RESP_OKAY : `UFM_RESP_SLVERR;
               wState_d = UFM_W_RESP;
            end
         end
         UFM_W_RESP: begin
            if (bready) begin
               bvalid_d = 1'b0;
               wState_d = UFM_W_IDLE;
            end
         end
         default: wState_d = UFM_W_IDLE;
      endcase
      awready_d = !awHeld_d;
      wready_d = !wHeld_d;
      if (rvalid && rready) begin
         rvalid_d = 1'b0;
      end
      if (arready && arvalid) begin
         rvalid_d = 1'b1;
         rresp_d = isMapped(araddr) ? `UFM_RESP_OKAY : `UFM_RESP_SLVERR;
         case (araddr)
            `UFM_OFS_LINE_FORMAT: rdata_d = {24'h0, lineFmt_q};
            `UFM_OFS_MODEM_OUT: rdata_d = {24'h0, modemCtl_q};
            `UFM_OFS_ENHANCED: rdata_d = {24'h0, enhanced_q};
            `UFM_OFS_STATUS: rdata_d = {23'h0, fifoEn_q, rxIrq, txIrq, trig_q};
            default: rdata_d = 32'h0; // fifo setup is write-only
         endcase
      end
      arready_d = !rvalid_d;
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         wState_q <= UFM_W_IDLE;
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         wAddr_q <= 8'h00;
         wData_q <= 32'h0;
         wStrb_q <= 4'h0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `UFM_RESP_OKAY;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rresp <= `UFM_RESP_OKAY;
         rdata <= 32'h0;
      end else begin
         wState_q <= wState_d;
         awHeld_q <= awHeld_d;
         wHeld_q <= wHeld_d;
         wAddr_q <= wAddr_d;
         wData_q <= wData_d;
         wStrb_q <= wStrb_d;
         awready <= awready_d;
         wready <= wready_d;
         bvalid <= bvalid_d;
         bresp <= bresp_d;
         arready <= arready_d;
         rvalid <= rvalid_d;
         rresp <= rresp_d;
         rdata <= rdata_d;
      end
   end
   // ----------------------------------------
   // registers and line control
   // ----------------------------------------
   logic [7:0] fifoSetup_d, lineFmt_d, modemCtl_d, enhanced_d;
   ufm_level_t trig_d;
   logic fifoEn_d, enh, loop, irMode, wrLow;
   logic rxToCore_d, serialTx_d, irTx_d, dtrN_d, rtsN_d, intOut_d, intOe_d;
   logic [3:0] modem_d, wordBits_d;
   logic [2:0] stop_d;
   logic txPar_d, rxErr_d, resume_d, store_d;
   always_comb begin
      fifoSetup_d = fifoSetup_q;
      lineFmt_d = lineFmt_q;
      modemCtl_d = modemCtl_q;
      enhanced_d = enhanced_q;
      trig_d = trig_q;
      fifoEn_d = fifoEn_q;
      enh = enhanced_q[`UFM_EF_ENHANCED];
      loop = modemCtl_q[`UFM_MC_LOOP];
      irMode = modemCtl_q[`UFM_MC_INFRARED] && enh;
      wrLow = wrDo && wStrb_q[0];
      if (wrLow) begin
         case (wAddr_q)
            `UFM_OFS_FIFO_SETUP: begin
               fifoEn_d = wData_q[`UFM_FS_ENABLE];
               if (wData_q[`UFM_FS_ENABLE]) begin
                  fifoSetup_d = wData_q[7:0];
                  // both fields arrive together; the transmit code wins in enhanced mode
                  trig_d = enh ? txTable(wData_q[5:4]) : rxTable(wData_q[7:6]);
               end
            end
            `UFM_OFS_LINE_FORMAT: lineFmt_d = wData_q[7:0];
            `UFM_OFS_MODEM_OUT: modemCtl_d = wData_q[7:0];
            `UFM_OFS_ENHANCED: enhanced_d = wData_q[7:0];
            default: ;
         endcase
      end
      if (lineFmt_q[`UFM_LF_BREAK]) begin
         serialTx_d = 1'b0;
      end else begin
         serialTx_d = (loop || irMode) ? 1'b1 : txBitIn;
      end
      // infrared line idles low, a space shows as a pulse
      irTx_d = irMode && !loop && (lineFmt_q[`UFM_LF_BREAK] || !txBitIn);
      if (loop) begin
         rxToCore_d = txBitIn && !lineFmt_q[`UFM_LF_BREAK];
         // cd follows the second user output
         modem_d = {modemCtl_q[`UFM_MC_INT_EN], modemCtl_q[`UFM_MC_RING],
            modemCtl_q[`UFM_MC_DTR], modemCtl_q[`UFM_MC_RTS]};
      end else begin
         rxToCore_d = irMode ? !irRxIn : rxPinIn;
         modem_d = ~{cdN, ring_indicator_n, dsrN, ctsN};
      end
      dtrN_d = loop || !modemCtl_q[`UFM_MC_DTR];
      rtsN_d = loop || !modemCtl_q[`UFM_MC_RTS];
      intOe_d = modemCtl_q[`UFM_MC_INT_EN];
      intOut_d = txIrq || rxIrq || extIrqIn;
      wordBits_d = {2'h0, lineFmt_q[1:0]} + 4'h5;
      if (!lineFmt_q[`UFM_LF_STOP]) begin
         stop_d = 3'h2;
      end else begin
         stop_d = (lineFmt_q[1:0] == 2'h0) ? 3'h3 : 3'h4;
      end
      txPar_d = parityOf(txWord, lineFmt_q);
      rxErr_d = rxParityErr;
      if (rxCharStrobe) begin
         rxErr_d = lineFmt_q[`UFM_LF_PAR_EN] && (rxParityIn != parityOf(rxWord, lineFmt_q));
      end
      resume_d = rxCharStrobe && modemCtl_q[`UFM_MC_XON_ANY] && enh;
      store_d = rxCharStrobe && !(rxIsFlowChar && swFlowActive);
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         fifoSetup_q <= `UFM_REG_RESET;
         lineFmt_q <= `UFM_REG_RESET;
         modemCtl_q <= `UFM_REG_RESET;
         enhanced_q <= `UFM_REG_RESET;
         trig_q <= `UFM_TRIG_RESET;
         fifoEn_q <= 1'b0;
         serialTxOut <= 1'b1;
         irTxOut <= 1'b0;
         rxToCore <= 1'b1;
         modemStatus <= 4'h0;
         dtrN <= 1'b1;
         rtsN <= 1'b1;
         intOe <= 1'b0;
         intOut <= 1'b0;
         wordBits <= 4'h5;
         stopHalves <= 3'h2;
         parityEnable <= 1'b0;
         txParityBit <= 1'b0;
         rxParityErr <= 1'b0;
         divisorSelect <= 1'b0;
         autoRtsReady <= 1'b0;
         xonAnyEnable <= 1'b0;
         resumeTx <= 1'b0;
         storeChar <= 1'b0;
         wakeIrqEnable <= 1'b0;
      end else begin
         fifoSetup_q <= fifoSetup_d;
         lineFmt_q <= lineFmt_d;
         modemCtl_q <= modemCtl_d;
         enhanced_q <= enhanced_d;
         trig_q <= trig_d;
         fifoEn_q <= fifoEn_d;
         serialTxOut <= serialTx_d;
         irTxOut <= irTx_d;
         rxToCore <= rxToCore_d;
         modemStatus <= modem_d;
         dtrN <= dtrN_d;
         rtsN <= rtsN_d;
         intOe <= intOe_d;
         intOut <= intOut_d;
         wordBits <= wordBits_d;
         stopHalves <= stop_d;
         parityEnable <= lineFmt_q[`UFM_LF_PAR_EN];
         txParityBit <= txPar_d;
         rxParityErr <= rxErr_d;
         divisorSelect <= lineFmt_q[`UFM_LF_DIVSEL];
         autoRtsReady <= modemCtl_q[`UFM_MC_RTS];
         xonAnyEnable <= modemCtl_q[`UFM_MC_XON_ANY] && enh;
         resumeTx <= resume_d;
         storeChar <= store_d;
         wakeIrqEnable <= fifoSetup_q[`UFM_FS_WAKE] && enh;
      end
   end
   // ----------------------------------------
   // submodules
   // ----------------------------------------
   ufm_prescaler #(.DIV(`UFM_PRESCALE_DIV)) u_prescale (
      .clock(clock),
      .rst(rst),
      .divEnable(modemCtl_q[`UFM_MC_PRESCALE] && enh),
      .baudTick(baudTick)
   );
   ufm_fifo_trigger #(.DEPTH(FIFO_DEPTH)) u_trigger (
      .clock(clock),
      .rst(rst),
      .trigLevel(trig_q),
      .txCount(txCount),
      .rxCount(rxCount),
      .txIrq(txIrq),
      .rxIrq(rxIrq)
   );
   // ----------------------------------------
   // checks
   // ----------------------------------------
   wake_gate_a: assert property (@(posedge clock) disable iff (rst)
      wakeIrqEnable |-> $past(enhanced_q[`UFM_EF_ENHANCED]))
      else $error("wake enable without enhanced mode");
   rx_table_a: assert property (@(posedge clock) disable iff (rst)
      (wrLow && wAddr_q == `UFM_OFS_FIFO_SETUP && wData_q[0] && !enh)
      |=> ##1 (u_trigger.trigLevel == rxTable($past(wData_q[7:6], 2))))
      else $error("receive trigger level wrong");
   ignore_setup_a: assert property (@(posedge clock) disable iff (rst)
      (wrLow && wAddr_q == `UFM_OFS_FIFO_SETUP && !wData_q[0])
      |=> $stable(trig_q) && $stable(fifoSetup_q))
      else $error("fifo setup changed without enable bit");
   break_low_a: assert property (@(posedge clock) disable iff (rst)
      lineFmt_q[`UFM_LF_BREAK] |=> !serialTxOut)
      else $error("break did not hold line low");
   dtr_pin_a: assert property (@(posedge clock) disable iff (rst)
      !loop |=> (dtrN == !$past(modemCtl_q[`UFM_MC_DTR])))
      else $error("terminal-ready pin wrong");
   int_enable_a: assert property (@(posedge clock) disable iff (rst)
      $rose(modemCtl_q[`UFM_MC_INT_EN]) |=> intOe)
      else $error("interrupt output not enabled");
   loop_rx_a: assert property (@(posedge clock) disable iff (rst)
      (loop && !lineFmt_q[`UFM_LF_BREAK]) |=> (rxToCore == $past(txBitIn)))
      else $error("loopback did not return transmit data");
   xon_any_a: assert property (@(posedge clock) disable iff (rst)
      (rxCharStrobe && xonAnyEnable && modemCtl_q[`UFM_MC_XON_ANY]) |=> resumeTx)
      else $error("xon-any did not resume transmit");
endmodule
`default_nettype wire

// *** verilog/ufm_fifo_trigger.sv ***
// transmit and receive fifo trigger events on one shared level
`default_nettype none
`include "ufm_map.svh"
module ufm_fifo_trigger #(
   parameter int DEPTH = `UFM_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // levels
   input wire ufm_pkg::ufm_level_t trigLevel,
   input wire ufm_pkg::ufm_level_t txCount,
   input wire ufm_pkg::ufm_level_t rxCount,
   // events
   output logic txIrq,
   output logic rxIrq
);
   import ufm_pkg::*;
   generate
      if (DEPTH < 30 || DEPTH > 63) begin : g_bad
         $error("fifo depth cannot hold the trigger table");
      end
   endgenerate
   logic filled_q;
   logic filled_d;
   logic txIrq_d;
   logic rxIrq_d;
   always_comb begin
      filled_d = filled_q;
      // remembers whether the last reload went above the level
      if (txCount > trigLevel) begin
         filled_d = 1'b1;
      end else if (txCount == 6'h00) begin
         filled_d = 1'b0;
      end
      txIrq_d = filled_q ? (txCount < trigLevel) : (txCount == 6'h00);
      rxIrq_d = (rxCount >= trigLevel);
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         filled_q <= 1'b0;
         txIrq <= 1'b0;
         rxIrq <= 1'b0;
      end else begin
         filled_q <= filled_d;
         txIrq <= txIrq_d;
         rxIrq <= rxIrq_d;
      end
   end
   rx_cross_a: assert property (@(posedge clock) disable iff (rst)
      (rxCount >= trigLevel) |=> rxIrq)
      else $error("receive trigger missed");
   tx_empty_a: assert property (@(posedge clock) disable iff (rst)
      (txCount == 6'h00) |=> txIrq)
      else $error("empty transmit fifo gave no event");
endmodule
`default_nettype wire

// *** verilog/ufm_map.svh ***
// register offsets, field positions, reset values and trigger levels
`ifndef UFM_MAP_SVH
`define UFM_MAP_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define UFM_OFS_FIFO_SETUP 8'h00
`define UFM_OFS_LINE_FORMAT 8'h04
`define UFM_OFS_MODEM_OUT 8'h08
`define UFM_OFS_ENHANCED 8'h0c
`define UFM_OFS_STATUS 8'h10
// ----------------------------------------
// field positions
// ----------------------------------------
`define UFM_FS_ENABLE 0
`define UFM_FS_WAKE 3
`define UFM_LF_STOP 2
`define UFM_LF_PAR_EN 3
`define UFM_LF_PAR_EVEN 4
`define UFM_LF_PAR_FORCE 5
`define UFM_LF_BREAK 6
`define UFM_LF_DIVSEL 7
`define UFM_MC_DTR 0
`define UFM_MC_RTS 1
`define UFM_MC_RING 2
`define UFM_MC_INT_EN 3
`define UFM_MC_LOOP 4
`define UFM_MC_XON_ANY 5
`define UFM_MC_INFRARED 6
`define UFM_MC_PRESCALE 7
`define UFM_EF_ENHANCED 4
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define UFM_REG_RESET 8'h00
`define UFM_TRIG_RESET 6'h08
`define UFM_TX_TRIG_0 6'h10
`define UFM_TX_TRIG_1 6'h08
`define UFM_TX_TRIG_2 6'h18
`define UFM_TX_TRIG_3 6'h1e
`define UFM_RX_TRIG_0 6'h08
`define UFM_RX_TRIG_1 6'h10
`define UFM_RX_TRIG_2 6'h18
`define UFM_RX_TRIG_3 6'h1c
`define UFM_PRESCALE_DIV 4
`define UFM_FIFO_DEPTH 32
`define UFM_RESP_OKAY 2'h0
`define UFM_RESP_SLVERR 2'h2
`endif

// *** verilog/ufm_pkg.sv ***
// types shared by the serial configuration block
`default_nettype none
package ufm_pkg;
   typedef logic [5:0] ufm_level_t;
   typedef enum logic [1:0] {
      UFM_W_IDLE = 2'b01,
      UFM_W_RESP = 2'b10
   } ufm_wstate_t;
endpackage
`default_nettype wire

// *** verilog/ufm_prescaler.sv ***
// baud clock enable: every cycle, or one cycle in four
`default_nettype none
`include "ufm_map.svh"
module ufm_prescaler #(
   parameter int DIV = `UFM_PRESCALE_DIV
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // control
   input wire logic divEnable,
   // enable out
   output logic baudTick
);
   import ufm_pkg::*;
   generate
      if (DIV < 2 || DIV > 16) begin : g_bad
         $error("prescaler divide out of range");
      end
   endgenerate
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic tick_d;
   always_comb begin
      cnt_d = 4'h0;
      tick_d = 1'b1;
      if (divEnable) begin
         tick_d = (cnt_q == 4'(DIV - 1));
         cnt_d = tick_d ? 4'h0 : cnt_q + 4'h1;
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_q <= 4'h0;
         baudTick <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         baudTick <= tick_d;
      end
   end
   // switching the divider off restarts the tick, so only a steady divider is judged
   div_four_a: assert property (@(posedge clock) disable iff (rst)
      (divEnable && baudTick) ##1 divEnable [*2]
      |=> !baudTick && !$past(baudTick) && !$past(baudTick, 2))
      else $error("prescaled tick came early");
endmodule
`default_nettype wire
